// ### inc/gtt_pkg.sv
/*
  package for the terminator and timeout unit: register map, reset values,
  timing counts and the bus carrier structs.
  assumes a 125 MHz clk and an avalon-mm slave with 32-bit data.
*/
// Functional notes
// - byte gap beyond limit raises io timeout
// - io limit 0..65535 ms, default 10010
// - dma message too long raises dma timeout
// - dma limit 0..65535 ms, default 10010
// - send one or two terminator bytes, optional eoi
// - four transmit sequences, optional second byte
// - defaults lf, cr lf, cr, lf cr with eoi
// - end reception on selected terminator match
// - byte with eoi always ends reception
// - receive choices lf, cr, comma, semicolon
package gtt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;     // w: selects, starts; r: selects only
  localparam logic [7:0] OFS_STATUS = 8'h04;   // r: state; w1c error flags
  localparam logic [7:0] OFS_IOLIM = 8'h08;    // io timeout in ms
  localparam logic [7:0] OFS_DMALIM = 8'h0c;   // dma timeout in ms
  localparam logic [7:0] OFS_TXSEQ0 = 8'h10;   // tx sequences 0..3 at +4 each
  localparam logic [7:0] OFS_RXCHR0 = 8'h20;   // rx chars 0..3 at +4 each
  // ctrl fields
  localparam int CTRL_TXSEL = 0;   // 2 bits
  localparam int CTRL_RXSEL = 2;   // 2 bits
  localparam int CTRL_DMAGO = 4;   // write 1: message start pulse
  localparam int CTRL_DMAEND = 5;  // write 1: message done pulse
  localparam int CTRL_TXTERM = 6;  // write 1: append terminator pulse
  // status fields
  localparam int ST_IOTO = 0;
  localparam int ST_DMATO = 1;
  localparam int ST_RXEND = 2;
  localparam int ST_TXBUSY = 3;
  localparam int ST_DMARUN = 4;
  // tx sequence fields: [7:0] first, [15:8] second, [16] second valid, [17] eoi
  localparam int TX_B2V = 16;
  localparam int TX_EOI = 17;
  // ascii terminators
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  // reset values
  localparam logic [15:0] IOLIM_RST = 16'd10010;
  localparam logic [15:0] DMALIM_RST = 16'd10010;
  localparam logic [17:0] TXSEQ_RST0 = {1'b1, 1'b0, 8'h00, CH_LF};
  localparam logic [17:0] TXSEQ_RST1 = {1'b1, 1'b1, CH_LF, CH_CR};
  localparam logic [17:0] TXSEQ_RST2 = {1'b1, 1'b0, 8'h00, CH_CR};
  localparam logic [17:0] TXSEQ_RST3 = {1'b1, 1'b1, CH_CR, CH_LF};
  localparam logic [8:0] RXCHR_RST0 = {1'b1, CH_LF};
  localparam logic [8:0] RXCHR_RST1 = {1'b1, CH_CR};
  localparam logic [8:0] RXCHR_RST2 = {1'b1, CH_COMMA};
  localparam logic [8:0] RXCHR_RST3 = {1'b1, CH_SEMI};
  // timing
  localparam int CLK_HZ = 125000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // bus carrier
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } gtt_req_t;
  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } gtt_byte_t;
  typedef enum {TX_IDLE, TX_FIRST, TX_SECOND} gtt_txst_t;
endpackage

// ### core/gtt_unit.sv
/*
  terminator framing and timeout supervision unit.
  assumes: avalon-mm master on clk; byte strobes from the handshake engine
  on the same clock (no synchronisers needed); txDone from that engine.
  limitation: a terminator request while a sequence is running is ignored.
*/
`timescale 1ns/1ps
module gtt_unit #(
  // cycles per millisecond tick; a bench may shorten it to keep runs brief
  parameter int TICK_CYC = gtt_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [7:0] avsAddress,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEoi,
  input wire logic txDone,
  output logic txValid,
  output logic [7:0] txData,
  output logic txEoi,
  output logic rxEnd,
  output logic ioTimeout,
  output logic dmaTimeout
);
  gtt_pkg::gtt_req_t req;  // bundled bus request
  gtt_pkg::gtt_byte_t rxb; // bundled receive byte
  assign req = '{read: avsRead, write: avsWrite, address: avsAddress, writedata: avsWritedata};
  assign rxb = '{data: rxData, eoi: rxEoi};

  // register state
  logic [1:0] txSel, next_txSel;
  logic [1:0] rxSel, next_rxSel;
  logic [15:0] ioLim, next_ioLim;
  logic [15:0] dmaLim, next_dmaLim;
  logic [17:0] txSeq [4];
  logic [17:0] next_txSeq [4];
  logic [8:0] rxChr [4];
  logic [8:0] next_rxChr [4];
  // sticky flags: set by events, cleared by writing one to status
  logic ioTo, next_ioTo;       // sticky io timeout
  logic dmaTo, next_dmaTo;     // sticky dma timeout
  logic rxEndF, next_rxEndF;   // sticky end of reception
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;         // one-cycle waitrequest release
  logic waitQ, next_waitQ;     // registered waitrequest, high while idle
  // timer state; the tick counter runs free from reset
  // 17 bits hold any tick count up to 131071 cycles
  logic [16:0] tickCnt, next_tickCnt;
  logic tick;
  logic [15:0] ioMs, next_ioMs;
  logic [15:0] dmaMs, next_dmaMs;
  logic ioArm, next_ioArm;     // armed once a byte has moved
  logic dmaRun, next_dmaRun;
  // transmit sequencer
  gtt_pkg::gtt_txst_t txSt, next_txSt;
  logic [7:0] txD, next_txD;
  logic txV, next_txV;
  logic txE, next_txE;
  logic [17:0] txLatch, next_txLatch;

  // decode strobes; a write is taken in the ack cycle only
  // a read is decoded while waitrequest is still high so data stand in the answer cycle
  logic wrCycle, rdCycle;
  logic goPulse, endPulse, termPulse, byteMoved, rxMatch;
  assign wrCycle = req.write && ack;
  assign rdCycle = req.read && !ack;
  assign goPulse = wrCycle && req.address == gtt_pkg::OFS_CTRL && req.writedata[gtt_pkg::CTRL_DMAGO];
  assign endPulse = wrCycle && req.address == gtt_pkg::OFS_CTRL && req.writedata[gtt_pkg::CTRL_DMAEND];
  assign termPulse = wrCycle && req.address == gtt_pkg::OFS_CTRL && req.writedata[gtt_pkg::CTRL_TXTERM];
  // any byte in either direction restarts the gap count
  assign byteMoved = rxValid || txDone;
  // compare against the one selected character only
  assign rxMatch = rxValid && (rxb.data == rxChr[rxSel][7:0]);
  assign tick = (tickCnt == 17'(TICK_CYC - 1));

  // register file and bus answer
  always_comb begin
    next_txSel = txSel;
    next_rxSel = rxSel;
    next_ioLim = ioLim;
    next_dmaLim = dmaLim;
    next_txSeq = txSeq;
    next_rxChr = rxChr;
    next_rdata = rdata;
    next_ack = 1'b0;
    if ((req.read || req.write) && !ack) begin
      next_ack = 1'b1; // answer one cycle after the request appears
    end
    // the pin follows the answer flop exactly, one edge at a time
    next_waitQ = !next_ack;
    // read data are captured one edge early and held until the next read
    if (rdCycle) begin
      // unmapped addresses read as zero
      if (req.address == gtt_pkg::OFS_CTRL) begin
        next_rdata = {28'h0000000, rxSel, txSel};
      end else if (req.address == gtt_pkg::OFS_STATUS) begin
        next_rdata = {27'h0000000, dmaRun, txSt != gtt_pkg::TX_IDLE, rxEndF, dmaTo, ioTo};
      end else if (req.address == gtt_pkg::OFS_IOLIM) begin
        next_rdata = {16'h0000, ioLim};
      end else if (req.address == gtt_pkg::OFS_DMALIM) begin
        next_rdata = {16'h0000, dmaLim};
      end else if (req.address[7:4] == gtt_pkg::OFS_TXSEQ0[7:4] && req.address[1:0] == 2'b00) begin
        next_rdata = {14'h0000, txSeq[req.address[3:2]]};
      end else if (req.address[7:4] == gtt_pkg::OFS_RXCHR0[7:4] && req.address[1:0] == 2'b00) begin
        next_rdata = {23'h000000, rxChr[req.address[3:2]]};
      end else begin
        next_rdata = 32'h00000000;
      end
    end
    // writes land at the edge that ends the answer cycle; unmapped ones are dropped
    if (wrCycle) begin
      if (req.address == gtt_pkg::OFS_CTRL) begin
        next_txSel = req.writedata[gtt_pkg::CTRL_TXSEL +: 2];
        next_rxSel = req.writedata[gtt_pkg::CTRL_RXSEL +: 2];
      end else if (req.address == gtt_pkg::OFS_IOLIM) begin
        next_ioLim = req.writedata[15:0];
      end else if (req.address == gtt_pkg::OFS_DMALIM) begin
        next_dmaLim = req.writedata[15:0];
      end else if (req.address[7:4] == gtt_pkg::OFS_TXSEQ0[7:4] && req.address[1:0] == 2'b00) begin
        next_txSeq[req.address[3:2]] = req.writedata[17:0];
      end else if (req.address[7:4] == gtt_pkg::OFS_RXCHR0[7:4] && req.address[1:0] == 2'b00) begin
        next_rxChr[req.address[3:2]] = req.writedata[8:0];
      end
    end
  end

  // clock enable low freezes the register file
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSel <= 2'b00;
      rxSel <= 2'b00;
      ioLim <= gtt_pkg::IOLIM_RST;
      dmaLim <= gtt_pkg::DMALIM_RST;
      txSeq[0] <= gtt_pkg::TXSEQ_RST0;
      txSeq[1] <= gtt_pkg::TXSEQ_RST1;
      txSeq[2] <= gtt_pkg::TXSEQ_RST2;
      txSeq[3] <= gtt_pkg::TXSEQ_RST3;
      rxChr[0] <= gtt_pkg::RXCHR_RST0;
      rxChr[1] <= gtt_pkg::RXCHR_RST1;
      rxChr[2] <= gtt_pkg::RXCHR_RST2;
      rxChr[3] <= gtt_pkg::RXCHR_RST3;
      rdata <= 32'h00000000;
      ack <= 1'b0;
      waitQ <= 1'b1;
    end else if (ce) begin
      txSel <= next_txSel;
      rxSel <= next_rxSel;
      ioLim <= next_ioLim;
      dmaLim <= next_dmaLim;
      txSeq <= next_txSeq;
      rxChr <= next_rxChr;
      rdata <= next_rdata;
      ack <= next_ack;
      waitQ <= next_waitQ;
    end
  end

  // timers and sticky flags; a new event beats a clear in the same cycle
  always_comb begin
    logic w1c;
    w1c = wrCycle && req.address == gtt_pkg::OFS_STATUS;
    next_tickCnt = tick ? 17'h00000 : tickCnt + 17'h00001;
    next_ioMs = ioMs;
    next_dmaMs = dmaMs;
    next_ioArm = ioArm;
    next_dmaRun = dmaRun;
    next_ioTo = ioTo && !(w1c && req.writedata[gtt_pkg::ST_IOTO]);
    next_dmaTo = dmaTo && !(w1c && req.writedata[gtt_pkg::ST_DMATO]);
    next_rxEndF = rxEndF && !(w1c && req.writedata[gtt_pkg::ST_RXEND]);
    // events below override those clears, so a timeout never gets lost
    // byte traffic restarts the gap count; ticks alone never clear it
    if (byteMoved) begin
      next_ioMs = 16'h0000;
      next_ioArm = 1'b1;
    end else if (ioArm && tick) begin
      // a limit of zero trips on the first tick after arming
      if (ioMs >= ioLim) begin
        next_ioTo = 1'b1;
        next_ioArm = 1'b0;
      end else begin
        next_ioMs = ioMs + 16'h0001;
      end
    end
    // dma timing runs only between a start and an end pulse
    if (goPulse) begin
      next_dmaMs = 16'h0000;
      next_dmaRun = 1'b1;
    end else if (endPulse) begin
      next_dmaRun = 1'b0;
    end else if (dmaRun && tick) begin
      if (dmaMs >= dmaLim) begin
        next_dmaTo = 1'b1;
        next_dmaRun = 1'b0;
      end else begin
        next_dmaMs = dmaMs + 16'h0001;
      end
    end
    // eoi ends reception whatever character is selected
    if (rxValid && (rxb.eoi || rxMatch)) begin
      next_rxEndF = 1'b1;
    end
  end

  // clock enable low freezes timers and flags as well
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt <= 17'h00000;
      ioMs <= 16'h0000;
      dmaMs <= 16'h0000;
      ioArm <= 1'b0;
      dmaRun <= 1'b0;
      ioTo <= 1'b0;
      dmaTo <= 1'b0;
      rxEndF <= 1'b0;
    end else if (ce) begin
      tickCnt <= next_tickCnt;
      ioMs <= next_ioMs;
      dmaMs <= next_dmaMs;
      ioArm <= next_ioArm;
      dmaRun <= next_dmaRun;
      ioTo <= next_ioTo;
      dmaTo <= next_dmaTo;
      rxEndF <= next_rxEndF;
    end
  end

  // terminator sequencer: holds each byte until the handshake engine takes it
  always_comb begin
    next_txSt = txSt;
    next_txD = txD;
    next_txV = txV;
    next_txE = txE;
    next_txLatch = txLatch;
    case (txSt)
      gtt_pkg::TX_IDLE: begin
        // only an idle sequencer accepts a request
        if (termPulse) begin
          // latch so a reselect mid-sequence cannot tear it
          next_txLatch = txSeq[txSel];
          next_txD = txSeq[txSel][7:0];
          next_txE = txSeq[txSel][gtt_pkg::TX_EOI] && !txSeq[txSel][gtt_pkg::TX_B2V];
          next_txV = 1'b1;
          next_txSt = gtt_pkg::TX_FIRST;
        end
      end
      gtt_pkg::TX_FIRST: begin
        if (txDone) begin
          // second byte carries eoi only when enabled
          if (txLatch[gtt_pkg::TX_B2V]) begin
            next_txD = txLatch[15:8];
            next_txE = txLatch[gtt_pkg::TX_EOI];
            next_txSt = gtt_pkg::TX_SECOND;
          end else begin
            // single byte: sequence complete
            next_txV = 1'b0;
            next_txE = 1'b0;
            next_txSt = gtt_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        // second byte taken: back to idle
        if (txDone) begin
          next_txV = 1'b0;
          next_txE = 1'b0;
          next_txSt = gtt_pkg::TX_IDLE;
        end
      end
    endcase
  end

  // clock enable low holds the offered byte steady
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSt <= gtt_pkg::TX_IDLE;
      txD <= 8'h00;
      txV <= 1'b0;
      txE <= 1'b0;
      txLatch <= 18'h00000;
    end else if (ce) begin
      txSt <= next_txSt;
      txD <= next_txD;
      txV <= next_txV;
      txE <= next_txE;
      txLatch <= next_txLatch;
    end
  end

  // outputs straight from flip-flops; waitrequest has its own flop so
  // the pin never comes from an inverter
  assign avsReaddata = rdata;
  assign avsWaitrequest = waitQ;
  assign txValid = txV;
  assign txData = txD;
  assign txEoi = txE;
  assign rxEnd = rxEndF;
  assign ioTimeout = ioTo;
  assign dmaTimeout = dmaTo;
endmodule // gtt_unit

// ### sim/gtt_bus_peer.sv
/*
  model of the far side: accepts terminator bytes, sends received bytes.
  assumes the same clk as the unit; tasks are called just after an edge.
*/
`timescale 1ns/1ps
module gtt_bus_peer (
  input wire logic clk,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txEoi,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxEoi,
  output logic txDone
);
  int lag = 0; // extra cycles before a byte is taken
  logic [8:0] got[$]; // bytes taken, eoi above data
  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxEoi = 1'b0;
    txDone = 1'b0;
  end
  // take each offered byte after lag cycles, one done pulse per byte
  always @(posedge clk) begin
    txDone <= 1'b0;
    if (txValid && !txDone) begin
      repeat (lag) @(posedge clk);
      got.push_back({txEoi, txData});
      txDone <= 1'b1;
    end
  end
  // one byte per call; idle data is inverted so a stale byte never matches
  task automatic send(input logic [7:0] d, input logic e);
    rxData <= d;
    rxEoi <= e;
    rxValid <= 1'b1;
    @(posedge clk);
    rxValid <= 1'b0;
    rxEoi <= 1'b0;
    rxData <= ~d;
    @(posedge clk);
  endtask
endmodule // gtt_bus_peer

// ### sim/gtt_unit_checker.sv
/*
  port assertions for the terminator and timeout unit.
  assumes ce stays high; one clock domain.
*/
`timescale 1ns/1ps
module gtt_unit_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [7:0] avsAddress,
  input wire logic [31:0] avsWritedata,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEoi,
  input wire logic txDone,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txEoi,
  input wire logic rxEnd,
  input wire logic ioTimeout,
  input wire logic dmaTimeout
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic stClr; // status write, may clear flags
  logic txGo; // accepted terminator request
  assign stClr = avsWrite && avsAddress == gtt_pkg::OFS_STATUS;
  assign txGo = avsWrite && !avsWaitrequest && avsAddress == gtt_pkg::OFS_CTRL && avsWritedata[gtt_pkg::CTRL_TXTERM];
  a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus answer late");
  a_eoi_ends: assert property (rxValid && rxEoi |=> rxEnd)
    else $error("eoi byte did not end reception");
  a_rxend_cause: assert property ($rose(rxEnd) |-> $past(rxValid))
    else $error("reception ended without a byte");
  a_tx_start: assert property (txGo && !txValid |=> txValid)
    else $error("terminator not offered");
  a_tx_hold: assert property (txValid && !txDone |=> txValid && $stable(txData) && $stable(txEoi))
    else $error("terminator byte changed before done");
  a_eoi_last: assert property (txEoi |-> txValid)
    else $error("eoi without a byte");
  a_io_sticky: assert property (ioTimeout && !stClr |=> ioTimeout)
    else $error("io timeout flag lost");
  a_dma_sticky: assert property (dmaTimeout && !stClr |=> dmaTimeout)
    else $error("dma timeout flag lost");
  cover property (txValid && txDone && txEoi);
  cover property ($rose(ioTimeout));
  cover property ($rose(dmaTimeout));
endmodule // gtt_unit_checker
bind gtt_unit gtt_unit_checker chk_u (.*);

// ### sim/testbench.sv
/*
  self-checking bench: bus tasks, terminator sends, receptions, timeouts.
  assumes the peer model and checker are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, avsRead, avsWrite, avsWaitrequest, txDone, txValid, txEoi, rxValid, rxEoi;
  logic rxEnd, ioTimeout, dmaTimeout;
  logic [7:0] avsAddress, rxData, txData;
  logic [31:0] avsWritedata, avsReaddata, q;
  int failures = 0;
  int n_checks = 0;
  logic [31:0] txRst[4] = '{32'h2000a, 32'h30a0d, 32'h2000d, 32'h30d0a}; // default sequences
  logic [7:0] rxChr[4] = '{8'h0a, 8'h0d, 8'h2c, 8'h3b}; // default characters
  localparam int TICK = 100; // shortened millisecond tick for the run
  // a single unit that answers every address on the bus
  gtt_unit #(.TICK_CYC(TICK)) dut_u (.clk(clk), .rst_n(rst_n), .ce(1'b1), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsAddress(avsAddress), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .rxValid(rxValid), .rxData(rxData), .rxEoi(rxEoi), .txDone(txDone),
    .txValid(txValid), .txData(txData), .txEoi(txEoi), .rxEnd(rxEnd), .ioTimeout(ioTimeout),
    .dmaTimeout(dmaTimeout));
  gtt_bus_peer peer_u (.clk(clk), .txValid(txValid), .txData(txData), .txEoi(txEoi), .rxValid(rxValid),
    .rxData(rxData), .rxEoi(rxEoi), .txDone(txDone));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avsRead <= !w;
    avsWrite <= w;
    avsAddress <= a;
    avsWritedata <= d;
    // no cycle count assumed: only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk);
  endtask
  // send terminator i and compare what the peer took against s
  task automatic term(input int i, input logic [31:0] s);
    int n = 0;
    peer_u.got.delete();
    // the send pulse uses the selection already in place, so select first
    bus(1'b1, 8'h00, 32'(i));
    bus(1'b1, 8'h00, 32'h40 | 32'(i));
    while ((txValid !== 1'b0 || peer_u.got.size() == 0) && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("tx count", s[16] ? 2 : 1, peer_u.got.size());
    chk("tx first", {s[17] & !s[16], s[7:0]}, peer_u.got[0]);
    if (s[16]) chk("tx second", {s[17], s[15:8]}, peer_u.got[1]);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog: the whole run needs under two thousand cycles at the short tick
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test;
  end
  initial begin
    int n;
    rst_n = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 8'h00;
    avsWritedata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 8'h08, 0); chk("io limit", 10010, q);
    bus(1'b0, 8'h0c, 0); chk("dma limit", 10010, q);
    bus(1'b0, 8'h3c, 0); chk("unmapped", 0, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'h10 + 8'(4 * i), 0); chk("tx seq", txRst[i], q);
      bus(1'b0, 8'h20 + 8'(4 * i), 0); chk("rx chr", {23'h1, rxChr[i]}, q);
      peer_u.lag = 3 * (i % 2);
      term(i, txRst[i]);
    end
    bus(1'b1, 8'h10, 32'hff); term(0, 32'hff);
    bus(1'b1, 8'h08, 32'hffff); bus(1'b0, 8'h08, 0); chk("io max", 32'hffff, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, 32'(i << 2));
      bus(1'b1, 8'h04, 32'h7);
      peer_u.send(8'h41, 1'b0); chk("rx plain", 0, rxEnd);
      peer_u.send(rxChr[i], 1'b0); chk("rx term", 1, rxEnd);
    end
    bus(1'b1, 8'h04, 32'h7);
    peer_u.send(8'h41, 1'b1); chk("rx eoi", 1, rxEnd);
    // limits of zero trip on the first tick after arming
    bus(1'b1, 8'h08, 0);
    bus(1'b1, 8'h0c, 0);
    bus(1'b1, 8'h04, 32'h7);
    bus(1'b1, 8'h00, 32'h10);
    peer_u.send(8'h41, 1'b0);
    n = 0;
    while (!(ioTimeout === 1'b1 && dmaTimeout === 1'b1) && n < 4 * TICK) begin
      @(posedge clk);
      n++;
    end
    bus(1'b0, 8'h04, 0); chk("timeouts", 32'h3, q & 32'h3);
    bus(1'b1, 8'h04, 32'h3); chk("io clear", 0, ioTimeout);
    chk("dma clear", 0, dmaTimeout);
    // a two-ms gap limit trips between two and three ticks after a byte
    bus(1'b1, 8'h08, 2);
    peer_u.send(8'h41, 1'b0);
    repeat (2 * TICK - 2) @(posedge clk);
    chk("io early", 0, ioTimeout);
    repeat (TICK + 4) @(posedge clk);
    chk("io late", 1, ioTimeout);
    // an end pulse before the limit stops the dma timer
    bus(1'b1, 8'h0c, 2);
    bus(1'b1, 8'h00, 32'h10);
    repeat (2 * TICK - 2) @(posedge clk);
    chk("dma early", 0, dmaTimeout);
    bus(1'b1, 8'h00, 32'h20);
    repeat (3 * TICK) @(posedge clk);
    chk("dma stopped", 0, dmaTimeout);
    bus(1'b1, 8'h00, 32'h10);
    repeat (3 * TICK + 4) @(posedge clk);
    chk("dma late", 1, dmaTimeout);
    stop_test;
  end
endmodule // testbench
